// ---- design/bvp_ctrl.sv ----
// Purpose: on/off, voltage select, ramps, modes and protection flags
// Assumes: comparators and I2C fields arrive synchronous to sys_clk_i
// Notes: target_code_o is the ramped code fed to the analog loop
//
// Overview of operation
// - Turn on only with enable pin and supply good; ready after delay.
// - Enable pin low keeps regulator off and pull-down engaged.
// - Two target codes A and B; GPIO or I2C bit selects one.
// - One target code step equals 10 mV of output.
// - Power-good sets past rise level, clears on fall or high level.
// - Power-good readable as status and driven to selected GPIOs.
// - Target rewrite, select toggle or GPIO toggle starts a ramp.
// - Step 10 mV per 8/4/2/1/0.5 us, separate up and down rates.
// - Any ramp forces PWM with synchronous rectification.
// - Disabled regulator enables pull-down unless disable field is 1.
// - Oscillator 8 MHz trimmed 160 kHz per code, 80 kHz switching.
// - Mode field of the selected setting picks PWM, PFM or auto.
// - One or two phases chosen by load current near 4 A.
// - Auto mode moves between PWM and PFM by load current.
// - After enable the I2C select bit picks setting A or B unless a GPIO selects.
// - Requested code is clamped to the maximum voltage limit.
// - Startup ramps at startup rate; host picks at most 5 mV/us.
// - Shutdown ramps at shutdown rate, or stops at once if none.
// - Current limit hit records event and interrupt unless masked.
// - Suppress bit drops over-current events during a ramp.
// - Warning and critical flags; critical disables regulator at once.
// - Event and mask for both thermal flags plus warning status mask.
// - Masks block only the interrupt; events still update.
`timescale 1ns/1ps
`default_nettype none
module bvp_ctrl (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic chip_enable_pin_i,
    input wire logic por_ok_i,
    input wire logic regulator_enable_i,
    input wire bvp_pkg::bvp_code_type target_voltage_a_i,
    input wire bvp_pkg::bvp_code_type target_voltage_b_i,
    input wire bvp_pkg::bvp_code_type max_voltage_limit_i,
    input wire logic voltage_setting_select_i,
    input wire logic gpio_select_cfg_i,
    input wire logic gpio_select_level_i,
    input wire logic [2:0] ramp_up_rate_i,
    input wire logic [2:0] ramp_down_rate_i,
    input wire logic [2:0] startup_ramp_rate_i,
    input wire logic [2:0] shutdown_ramp_rate_i,
    input wire logic [1:0] pulldown_disable_i,
    input wire logic [3:0] oscillator_trim_i,
    input wire logic [1:0] setting_a_op_mode_i,
    input wire logic [1:0] setting_b_op_mode_i,
    input wire logic load_above_4a_i,
    input wire logic load_light_i,
    input wire logic vout_above_pg_rise_i,
    input wire logic vout_below_pg_fall_i,
    input wire logic vout_above_hv_i,
    input wire logic [bvp_pkg::GPIO_N-1:0] gpio_pg_mode_i,
    input wire logic current_limit_hit_i,
    input wire logic overcurrent_irq_mask_i,
    input wire logic ramp_overcurrent_suppress_i,
    input wire logic overcurrent_event_clr_i,
    input wire logic temp_warn_i,
    input wire logic thermal_critical_flag_i,
    input wire logic thermal_warning_event_mask_i,
    input wire logic thermal_critical_event_mask_i,
    input wire logic thermal_status_irq_mask_i,
    input wire logic thermal_warning_event_clr_i,
    input wire logic thermal_critical_event_clr_i,
    output logic ctrl_ready_o,
    output logic regulator_on_o,
    output logic pulldown_on_o,
    output bvp_pkg::bvp_code_type target_code_o,
    output logic ramp_active_o,
    output logic op_pwm_o,
    output logic op_pfm_o,
    output logic two_phase_o,
    output logic [15:0] osc_freq_khz_o,
    output logic power_good_flag_o,
    output logic [bvp_pkg::GPIO_N-1:0] gpio_pg_o,
    output logic thermal_warning_flag_o,
    output logic thermal_critical_flag_o,
    output logic overcurrent_event_o,
    output logic thermal_warning_event_o,
    output logic thermal_critical_event_o,
    output logic irq_o
);
    import bvp_pkg::*;
    localparam int EN_CNT_W = $clog2(EN_DELAY_CYC + 1);

    typedef struct packed {
        bvp_state_type state;
        logic [EN_CNT_W-1:0] en_cnt;
        logic ready;
        logic crit_trip;
        logic [CODE_W-1:0] tgt;
        logic on;
        logic pd;
        logic ramp;
        logic pwm;
        logic pfm;
        logic two_ph;
        logic [15:0] osc;
        logic pg;
        logic [GPIO_N-1:0] gpio_pg;
        logic tw;
        logic tc;
        logic irq;
    } bvp_ctl_type;

    bvp_ctl_type r_reg;
    bvp_ctl_type r_next;
    logic sel_b;
    logic [CODE_W-1:0] raw;
    logic [CODE_W-1:0] req;
    logic [CODE_W-1:0] goal;
    logic running;
    logic ramp_now;
    logic ramp_up;
    logic [2:0] rate;
    logic tick;
    logic supply_ok;
    logic oc_set;
    logic oc_evt;
    logic tw_evt;
    logic tc_evt;
    logic [1:0] mode;

    // ==========================================================
    // target selection and clamp
    always_comb begin
        sel_b = gpio_select_cfg_i ? gpio_select_level_i
                                  : voltage_setting_select_i;
        raw = sel_b ? target_voltage_b_i : target_voltage_a_i;
        req = (raw > max_voltage_limit_i) ? max_voltage_limit_i : raw;
        mode = sel_b ? setting_b_op_mode_i : setting_a_op_mode_i;
        running = (r_reg.state == ST_START) || (r_reg.state == ST_ON)
                  || (r_reg.state == ST_SHDN);
        goal = (r_reg.state == ST_SHDN) ? CODE_ZERO : req;
        ramp_now = running && (r_reg.tgt != goal);
        ramp_up = r_reg.tgt < goal;
        supply_ok = chip_enable_pin_i && por_ok_i;
        oc_set = supply_ok && current_limit_hit_i
                 && !(ramp_overcurrent_suppress_i && ramp_now);
    end

    // ramp rate per phase of operation
    always_comb begin
        unique case (r_reg.state)
            ST_START: rate = startup_ramp_rate_i;
            ST_SHDN: rate = 3'(shutdown_ramp_rate_i - 3'h1);
            default: rate = ramp_up ? ramp_up_rate_i : ramp_down_rate_i;
        endcase
    end

    bvp_step_timer u_tmr (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .run_i(ramp_now),
        .rate_i(rate),
        .tick_o(tick)
    );

    // ==========================================================
    // sequencer
    always_comb begin
        r_next = r_reg;
        if (!supply_ok) begin
            r_next = '0;
            r_next.state = ST_OFF;
        end else begin
            if (!regulator_enable_i) begin
                r_next.crit_trip = 1'b0;
            end
            if (tick && ramp_now) begin
                r_next.tgt = ramp_up ? r_reg.tgt + 1'b1
                                     : r_reg.tgt - 1'b1;
            end
            unique case (r_reg.state)
                ST_OFF: begin
                    if (r_reg.en_cnt == EN_CNT_W'(EN_DELAY_CYC - 1)) begin
                        r_next.ready = 1'b1;
                        r_next.state = ST_IDLE;
                    end else begin
                        r_next.en_cnt = r_reg.en_cnt + 1'b1;
                    end
                end
                ST_IDLE: begin
                    r_next.tgt = CODE_ZERO;
                    if (regulator_enable_i && !r_reg.crit_trip) begin
                        r_next.state = ST_START;
                    end
                end
                ST_START, ST_ON: begin
                    if (r_reg.state == ST_START && !ramp_now) begin
                        r_next.state = ST_ON;
                    end
                    if (!regulator_enable_i) begin
                        if (shutdown_ramp_rate_i == SHDN_NONE) begin
                            r_next.state = ST_IDLE;
                            r_next.tgt = CODE_ZERO;
                        end else begin
                            r_next.state = ST_SHDN;
                        end
                    end
                end
                ST_SHDN: begin
                    if (r_reg.tgt == CODE_ZERO) begin
                        r_next.state = ST_IDLE;
                    end
                end
                default: begin
                    r_next.state = ST_OFF;
                end
            endcase
            if (thermal_critical_flag_i && r_reg.state != ST_OFF) begin
                r_next.state = ST_IDLE;
                r_next.tgt = CODE_ZERO;
                r_next.crit_trip = 1'b1;
            end
        end
        // outputs from the next state
        r_next.on = (r_next.state == ST_START) || (r_next.state == ST_ON)
                    || (r_next.state == ST_SHDN);
        r_next.pd = !supply_ok || (!r_next.on
                    && pulldown_disable_i != PD_DISABLE_CODE);
        r_next.ramp = r_next.on && ramp_now;
        r_next.pwm = r_next.on && (r_next.ramp || mode == MODE_PWM
            || (mode != MODE_PFM && !load_light_i));
        r_next.pfm = r_next.on && !r_next.pwm;
        r_next.two_ph = r_next.on && load_above_4a_i;
        r_next.osc = 16'(OSC_BASE_KHZ + OSC_STEP_KHZ
                     * int'($signed(oscillator_trim_i)));
        if (!r_next.on || vout_below_pg_fall_i || vout_above_hv_i) begin
            r_next.pg = 1'b0;
        end else if (vout_above_pg_rise_i) begin
            r_next.pg = 1'b1;
        end
        r_next.gpio_pg = gpio_pg_mode_i & {GPIO_N{r_next.pg}};
        r_next.tw = supply_ok && temp_warn_i;
        r_next.tc = supply_ok && thermal_critical_flag_i;
        r_next.irq = (oc_evt && !overcurrent_irq_mask_i)
                     || (tw_evt && !thermal_warning_event_mask_i)
                     || (tc_evt && !thermal_critical_event_mask_i)
                     || (r_next.tw && !thermal_status_irq_mask_i);
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // sticky events, masks act only on irq
    bvp_sticky_evt u_oc (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .set_i(oc_set),
        .clr_i(overcurrent_event_clr_i),
        .flag_o(oc_evt)
    );
    bvp_sticky_evt u_tw (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .set_i(supply_ok && temp_warn_i && !r_reg.tw),
        .clr_i(thermal_warning_event_clr_i),
        .flag_o(tw_evt)
    );
    bvp_sticky_evt u_tc (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .set_i(supply_ok && thermal_critical_flag_i && !r_reg.tc),
        .clr_i(thermal_critical_event_clr_i),
        .flag_o(tc_evt)
    );

    // output map
    assign ctrl_ready_o = r_reg.ready;
    assign regulator_on_o = r_reg.on;
    assign pulldown_on_o = r_reg.pd;
    assign target_code_o = r_reg.tgt;
    assign ramp_active_o = r_reg.ramp;
    assign op_pwm_o = r_reg.pwm;
    assign op_pfm_o = r_reg.pfm;
    assign two_phase_o = r_reg.two_ph;
    assign osc_freq_khz_o = r_reg.osc;
    assign power_good_flag_o = r_reg.pg;
    assign gpio_pg_o = r_reg.gpio_pg;
    assign thermal_warning_flag_o = r_reg.tw;
    assign thermal_critical_flag_o = r_reg.tc;
    assign overcurrent_event_o = oc_evt;
    assign thermal_warning_event_o = tw_evt;
    assign thermal_critical_event_o = tc_evt;
    assign irq_o = r_reg.irq;

    // ==========================================================
    // checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_off;
        !chip_enable_pin_i;
    endsequence
    sequence s_crit;
        supply_ok && thermal_critical_flag_i;
    endsequence
    sequence s_pg_bad;
        vout_below_pg_fall_i || vout_above_hv_i;
    endsequence

    property p_off;
        s_off |=> pulldown_on_o && !regulator_on_o && !ctrl_ready_o;
    endproperty
    a_off: assert property (p_off) else $error("off state wrong");

    property p_ready;
        $rose(ctrl_ready_o) |-> $past(supply_ok);
    endproperty
    a_ready: assert property (p_ready) else $error("early ready");

    property p_pd;
        supply_ok && pulldown_disable_i != PD_DISABLE_CODE
            |=> pulldown_on_o == !regulator_on_o;
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down wrong");

    property p_step;
        regulator_on_o && $past(regulator_on_o)
            && $changed(target_code_o)
            |-> (8'(target_code_o - $past(target_code_o)) == 8'h01)
            || (8'(target_code_o - $past(target_code_o)) == 8'hFF);
    endproperty
    a_step: assert property (p_step) else $error("step not one code");

    property p_clamp;
        running && !ramp_now |-> target_code_o <= max_voltage_limit_i;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp broken");

    property p_pwm;
        ramp_active_o |-> op_pwm_o && !op_pfm_o;
    endproperty
    a_pwm: assert property (p_pwm) else $error("ramp not in pwm");

    property p_crit;
        s_crit |=> !regulator_on_o ##1 thermal_critical_event_o;
    endproperty
    a_crit: assert property (p_crit) else $error("crit no shutdown");

    property p_pg;
        s_pg_bad |=> !power_good_flag_o && gpio_pg_o == '0;
    endproperty
    a_pg: assert property (p_pg) else $error("power-good held");

    property p_oc;
        current_limit_hit_i && supply_ok && !ramp_overcurrent_suppress_i
            |=> overcurrent_event_o;
    endproperty
    a_oc: assert property (p_oc) else $error("oc not recorded");

    property p_oc_sup;
        current_limit_hit_i && ramp_overcurrent_suppress_i && ramp_now
            && !overcurrent_event_o |=> !overcurrent_event_o;
    endproperty
    a_oc_sup: assert property (p_oc_sup) else $error("oc not hidden");

    property p_warn_irq;
        supply_ok && temp_warn_i && !thermal_status_irq_mask_i |=> irq_o;
    endproperty
    a_warn_irq: assert property (p_warn_irq) else $error("no warn irq");
endmodule
`default_nettype wire

// ---- design/bvp_pkg.sv ----
// Purpose: shared constants and types for the buck control logic
// Assumes: 10 MHz system clock
// Notes: ramp interval table is indexed by the 3-bit rate fields
package bvp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int EN_DELAY_US = 1000;
    // longest wait, rounded down
    localparam int EN_DELAY_CYC = EN_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int STEP_NUM = 5;
    // step intervals 8, 4, 2, 1, 0.5 us, held in ns
    localparam int STEP_NS [0:STEP_NUM-1] = '{8000, 4000, 2000, 1000, 500};
    localparam int STEP_CNT_W = 7;
    // ==========================================================
    // voltage code
    localparam int CODE_W = 8;
    localparam int STEP_MV = 10;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    typedef logic [CODE_W-1:0] bvp_code_type;
    // ==========================================================
    // field values
    localparam logic [1:0] PD_DISABLE_CODE = 2'h1;
    localparam logic [2:0] SHDN_NONE = 3'h0;
    localparam logic [2:0] RATE_MAX_IDX = 3'h4;
    localparam int GPIO_N = 5;
    localparam int OSC_BASE_KHZ = 8000;
    localparam int OSC_STEP_KHZ = 160;
    typedef enum logic [1:0] {
        MODE_AUTO = 2'b00,
        MODE_PWM = 2'b01,
        MODE_PFM = 2'b10
    } bvp_mode_type;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_ON = 3'b011,
        ST_SHDN = 3'b100
    } bvp_state_type;
endpackage

// ---- design/bvp_step_timer.sv ----
// Purpose: ramp step timer, one tick per programmed interval
// Assumes: rate index above the table top uses the fastest interval
// Notes: counter restarts whenever run drops
`timescale 1ns/1ps
`default_nettype none
module bvp_step_timer (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic [2:0] rate_i,
    output logic tick_o
);
    import bvp_pkg::*;
    typedef struct packed {
        logic [STEP_CNT_W-1:0] cnt;
        logic tick;
    } bvp_tmr_type;
    bvp_tmr_type t_reg;
    bvp_tmr_type t_next;
    logic [2:0] idx;
    logic [STEP_CNT_W-1:0] last;

    // ==========================================================
    // interval count
    always_comb begin
        idx = (rate_i > RATE_MAX_IDX) ? RATE_MAX_IDX : rate_i;
        last = STEP_CNT_W'(STEP_NS[idx] / CLK_PERIOD_NS - 1);
        t_next = t_reg;
        t_next.tick = 1'b0;
        if (!run_i) begin
            t_next.cnt = '0;
        end else if (t_reg.cnt >= last) begin
            t_next.cnt = '0;
            t_next.tick = 1'b1;
        end else begin
            t_next.cnt = t_reg.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign tick_o = t_reg.tick;
endmodule
`default_nettype wire

// ---- design/bvp_sticky_evt.sv ----
// Purpose: sticky event bit with software clear
// Assumes: clear is a one-cycle write pulse
// Notes: a set in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module bvp_sticky_evt (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    import bvp_pkg::*;
    typedef struct packed {
        logic flag;
    } bvp_evt_type;
    bvp_evt_type e_reg;
    bvp_evt_type e_next;

    // ==========================================================
    // set over clear
    always_comb begin
        e_next = e_reg;
        if (set_i) begin
            e_next.flag = 1'b1;
        end else if (clr_i) begin
            e_next.flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            e_reg <= '0;
        end else begin
            e_reg <= e_next;
        end
    end

    assign flag_o = e_reg.flag;
endmodule
`default_nettype wire

// ---- verif/buck_voltage_protection_ctrl_tb.sv ----
// Purpose: self-checking bench for the buck control block
// Assumes: inputs change on the falling clock edge
// Notes: enable delay is waited in full, about 10000 cycles
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_protection_ctrl_tb;
    import bvp_pkg::*;
    // ==========================================================
    // signals named as the design ports
    logic sys_clk_i = 1'b0;
    logic nrst_i, chip_enable_pin_i, por_ok_i, regulator_enable_i, host_want;
    logic voltage_setting_select_i, gpio_select_cfg_i, gpio_select_level_i;
    logic load_above_4a_i, load_light_i, vout_above_pg_rise_i;
    logic vout_below_pg_fall_i, vout_above_hv_i, current_limit_hit_i;
    logic overcurrent_irq_mask_i, ramp_overcurrent_suppress_i;
    logic overcurrent_event_clr_i, temp_warn_i, thermal_critical_flag_i;
    logic thermal_warning_event_mask_i, thermal_critical_event_mask_i;
    logic thermal_status_irq_mask_i, thermal_warning_event_clr_i;
    logic thermal_critical_event_clr_i;
    bvp_code_type target_voltage_a_i, target_voltage_b_i, max_voltage_limit_i;
    logic [2:0] ramp_up_rate_i, ramp_down_rate_i, startup_ramp_rate_i;
    logic [2:0] shutdown_ramp_rate_i;
    logic [1:0] pulldown_disable_i, setting_a_op_mode_i, setting_b_op_mode_i;
    logic [3:0] oscillator_trim_i;
    logic [GPIO_N-1:0] gpio_pg_mode_i, gpio_pg_o;
    logic ctrl_ready_o, regulator_on_o, pulldown_on_o, ramp_active_o;
    logic op_pwm_o, op_pfm_o, two_phase_o, power_good_flag_o, irq_o;
    logic thermal_warning_flag_o, thermal_critical_flag_o, overcurrent_event_o;
    logic thermal_warning_event_o, thermal_critical_event_o;
    bvp_code_type target_code_o;
    logic [15:0] osc_freq_khz_o;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    // row: mode, light, heavy, trim, rise, fall, high, {pwm,pfm,two,pg,freq}
    typedef struct {
        logic [1:0] md;
        logic lt, hv;
        logic [3:0] tr;
        logic r, f, h;
        logic [19:0] ex;
    } bvp_row_type;
    bvp_row_type rows [5] = '{
        '{2'h1, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 20'h91F40},
        '{2'h2, 1'b0, 1'b0, 4'h1, 1'b0, 1'b0, 1'b0, 20'h51FE0},
        '{2'h0, 1'b1, 1'b0, 4'h3, 1'b0, 1'b1, 1'b0, 20'h42120},
        '{2'h0, 1'b0, 1'b1, 4'hF, 1'b1, 1'b0, 1'b0, 20'hB1EA0},
        '{2'h3, 1'b0, 1'b1, 4'h8, 1'b1, 1'b0, 1'b1, 20'hA1A40}};
    // ==========================================================
    // clock, design and host model
    always #50 sys_clk_i = ~sys_clk_i;
    bvp_ctrl dut (.*);
    bvp_host_model host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .ready_i(ctrl_ready_o), .want_on_i(host_want), .rate_req_i(3'h6),
        .enable_o(regulator_enable_i), .startup_rate_o(startup_ramp_rate_i));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic wait_code(input bvp_code_type c, output int k);
        k = 0;
        while (target_code_o !== c && k < 11000) begin
            cyc(1);
            k++;
        end
        // limit ran out, count it as a mismatch
        if (target_code_o !== c) begin
            chk(target_code_o, c);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog, about four times the expected run
    initial begin
        #4000000;
        n_fail++;
        finish_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        {nrst_i, chip_enable_pin_i, por_ok_i, host_want} = 4'h0;
        {voltage_setting_select_i, gpio_select_cfg_i, gpio_select_level_i} = 3'h0;
        {load_above_4a_i, load_light_i, vout_above_pg_rise_i} = 3'h0;
        {vout_below_pg_fall_i, vout_above_hv_i, current_limit_hit_i} = 3'h0;
        {overcurrent_irq_mask_i, ramp_overcurrent_suppress_i} = 2'h0;
        {overcurrent_event_clr_i, temp_warn_i, thermal_critical_flag_i} = 3'h0;
        {thermal_warning_event_mask_i, thermal_critical_event_mask_i} = 2'h3;
        {thermal_status_irq_mask_i, thermal_warning_event_clr_i} = 2'h2;
        thermal_critical_event_clr_i = 1'b0;
        {target_voltage_a_i, target_voltage_b_i} = 16'h0503;
        max_voltage_limit_i = 8'hFF;
        {ramp_up_rate_i, ramp_down_rate_i, shutdown_ramp_rate_i} = 9'h118;
        {pulldown_disable_i, setting_a_op_mode_i, setting_b_op_mode_i} = 6'h09;
        oscillator_trim_i = 4'h0;
        gpio_pg_mode_i = 5'h05;
        cyc(5);
        nrst_i = 1'b1;
        cyc(1);
        chk({ctrl_ready_o, regulator_on_o, pulldown_on_o}, 3'h1);
        {chip_enable_pin_i, por_ok_i, host_want} = 3'h7;
        wait_code(8'h01, n);
        chk(n > 10000 && n < 10200, 1'b1);
        chk({ramp_active_o, op_pwm_o, op_pfm_o}, 3'h6);
        wait_code(8'h02, n);
        chk(n, 20);
        wait_code(8'h05, n);
        cyc(2);
        chk({ctrl_ready_o, ramp_active_o, op_pfm_o, target_code_o},
            11'h505);
        $display("test startup done");
        foreach (rows[i]) begin
            setting_a_op_mode_i = rows[i].md;
            {load_light_i, load_above_4a_i} = {rows[i].lt, rows[i].hv};
            oscillator_trim_i = rows[i].tr;
            vout_above_pg_rise_i = rows[i].r;
            {vout_below_pg_fall_i, vout_above_hv_i} = {rows[i].f, rows[i].h};
            cyc(3);
            chk({op_pwm_o, op_pfm_o, two_phase_o, power_good_flag_o,
                osc_freq_khz_o}, rows[i].ex);
            chk(gpio_pg_o, rows[i].ex[16] ? 5'h05 : 5'h00);
        end
        $display("test mode table done");
        {target_voltage_a_i, max_voltage_limit_i} = 16'h3008;
        wait_code(8'h06, n);
        wait_code(8'h07, n);
        chk(n, 5);
        cyc(30);
        chk(target_code_o, 8'h08);
        voltage_setting_select_i = 1'b1;
        wait_code(8'h07, n);
        wait_code(8'h06, n);
        chk(n, 10);
        {gpio_select_cfg_i, gpio_select_level_i} = 2'h2;
        wait_code(8'h08, n);
        chk(n < 20, 1'b1);
        gpio_select_level_i = 1'b1;
        wait_code(8'h03, n);
        chk(n < 60, 1'b1);
        $display("test voltage change done");
        current_limit_hit_i = 1'b1;
        cyc(1);
        current_limit_hit_i = 1'b0;
        cyc(2);
        chk({overcurrent_event_o, irq_o}, 2'h3);
        {overcurrent_event_clr_i, overcurrent_irq_mask_i} = 2'h3;
        cyc(1);
        {overcurrent_event_clr_i, current_limit_hit_i} = 2'h1;
        cyc(1);
        current_limit_hit_i = 1'b0;
        cyc(2);
        chk({overcurrent_event_o, irq_o}, 2'h2);
        overcurrent_event_clr_i = 1'b1;
        cyc(1);
        {overcurrent_event_clr_i, ramp_overcurrent_suppress_i} = 2'h1;
        gpio_select_level_i = 1'b0;
        cyc(3);
        current_limit_hit_i = 1'b1;
        cyc(1);
        current_limit_hit_i = 1'b0;
        cyc(2);
        chk({ramp_active_o, overcurrent_event_o}, 2'h2);
        $display("test over-current done");
        {temp_warn_i, thermal_status_irq_mask_i} = 2'h2;
        cyc(2);
        chk({thermal_warning_flag_o, thermal_warning_event_o, irq_o},
            3'h7);
        thermal_critical_flag_i = 1'b1;
        cyc(2);
        chk({thermal_critical_flag_o, thermal_critical_event_o,
            regulator_on_o, pulldown_on_o}, 4'hD);
        {thermal_critical_flag_i, temp_warn_i, host_want} = 3'h0;
        cyc(3);
        {host_want, thermal_critical_event_clr_i} = 2'h3;
        cyc(1);
        thermal_critical_event_clr_i = 1'b0;
        cyc(2);
        chk({regulator_on_o, thermal_critical_event_o},
            2'h2);
        {pulldown_disable_i, host_want} = 3'h2;
        cyc(3);
        chk({regulator_on_o, pulldown_on_o, target_code_o}, 10'h000);
        chip_enable_pin_i = 1'b0;
        cyc(3);
        chk({regulator_on_o, pulldown_on_o}, 2'h1);
        $display("test protection done");
        finish_test();
    end
endmodule
`default_nettype wire

// ---- verif/bvp_host_model.sv ----
// Purpose: host side model driving regulator enable and startup rate
// Assumes: ready level from the block marks the end of the enable delay
// Notes: startup rates faster than 5 mV/us are never handed on
`timescale 1ns/1ps
`default_nettype none
module bvp_host_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ready_i,
    input wire logic want_on_i,
    input wire logic [2:0] rate_req_i,
    output logic enable_o,
    output logic [2:0] startup_rate_o
);
    // ==========================================================
    // enable request, held back until the block is ready
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            enable_o <= 1'b0;
        end else begin
            enable_o <= want_on_i & ready_i;
        end
    end
    // index 2 is 10 mV per 2 us, the fastest safe rate
    assign startup_rate_o = (rate_req_i > 3'h2) ? 3'h2 : rate_req_i;
endmodule
`default_nettype wire
